// ### swl_blk_map.sv
// Destination blocking map derived from the lock state
`timescale 1ns/10ps
module swl_blk_map (
    // Lock state
    input  wire logic                       dn_locked_i,
    input  wire logic                       up_locked_i,
    input  wire logic [swl_pkg::PW-1:0]     port_i,
    // Blocking map
    output logic [swl_pkg::NPORT-1:0]       to_dn_o,
    output logic                            to_up_o
);

    // Only the locked downstream port is a blocked destination
    genvar g;
    generate
        for (g = 0; g < swl_pkg::NPORT; g = g + 1) begin : g_dst
            assign to_dn_o[g] = dn_locked_i && (g != 0) &&
                                (port_i == swl_pkg::PW'(g));
        end
    endgenerate

    // Upstream is blocked only once the whole switch is locked
    assign to_up_o = up_locked_i;

endmodule

// ### swl_drain.sv
// Posted-queue drain detector for one selected port
`timescale 1ns/10ps
module swl_drain (
    // Selection
    input  wire logic                       wait_i,
    input  wire logic [swl_pkg::PW-1:0]     port_i,
    // Queue state
    input  wire logic [swl_pkg::NPORT-1:0]  empty_i,
    // Result
    output logic                            done_o
);

    // Drained once the selected posted queue reports empty
    function automatic logic sel_bit(input logic [swl_pkg::NPORT-1:0] v,
                                     input logic [swl_pkg::PW-1:0] p);
        sel_bit = v[p];
    endfunction

    // Only meaningful while the controller waits
    always_comb begin
        done_o = wait_i && sel_bit(empty_i, port_i);
    end

endmodule

// ### swl_ep_model.sv
// Behavioural endpoint on a downstream port that answers forwarded locked reads
`timescale 1ns/10ps
module swl_ep_model (
    // Clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  rst_n_i,
    // Test control
    input  wire logic                  fail_i,
    input  wire logic [1:0]            delay_i,
    // Switch side
    input  wire swl_pkg::swl_fwd_s     fwd_i,
    input  wire logic                  dn_take_i,
    output swl_pkg::swl_dn_cpl_s       dn_cpl_o
);
    // ==========================================================
    // Answer state
    logic              pend;
    logic              busy;
    logic [1:0]        wait_cnt;
    logic [2:0]        port;
    swl_pkg::swl_cpl_e kind;

    // Only locked completions come back; a failed lock returns one without data
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pend     <= 1'b0;
            busy     <= 1'b0;
            wait_cnt <= 2'h0;
            port     <= 3'h0;
            kind     <= swl_pkg::SWL_CPL_DLK;
        end else if (fwd_i.rdlk) begin
            pend     <= 1'b1;
            wait_cnt <= delay_i;
            port     <= fwd_i.port;
            kind     <= fail_i ? swl_pkg::SWL_CPL_LK : swl_pkg::SWL_CPL_DLK;
        end else if (busy) begin
            busy <= !dn_take_i; // Held until the switch takes it
        end else if (pend) begin
            pend     <= (wait_cnt != 2'h0);
            busy     <= (wait_cnt == 2'h0);
            wait_cnt <= wait_cnt - 2'h1;
        end
    end

    // Released lines show a changed pattern so stale values never pass
    always_comb begin
        dn_cpl_o.valid = busy;
        dn_cpl_o.kind  = busy ? kind : swl_pkg::SWL_CPL_OTHER;
        dn_cpl_o.port  = busy ? port : ~port;
    end
endmodule

// ### swl_lock_ctrl.sv
// Lock sequence controller: locked read, completion, unlock and blocking
`timescale 1ns/10ps
module swl_lock_ctrl (
    // Clock, reset, enable
    input  wire logic                       clk_i,
    input  wire logic                       rst_n_i,
    input  wire logic                       ce_i,
    // Requests arriving on the upstream port
    input  wire swl_pkg::swl_up_req_s       up_req_i,
    output logic                            up_take_o,
    // Locked completions from downstream ports
    input  wire swl_pkg::swl_dn_cpl_s       dn_cpl_i,
    output logic                            dn_take_o,
    // Posted queue state, one bit per port
    input  wire logic [swl_pkg::NPORT-1:0]  up_to_dn_empty_i,
    input  wire logic [swl_pkg::NPORT-1:0]  dn_to_up_empty_i,
    // Forwarding strobes
    output swl_pkg::swl_fwd_s               fwd_o,
    // Blocking map for sources other than root and locked port
    output logic [swl_pkg::NPORT-1:0]       blk_to_dn_o,
    output logic                            blk_to_up_o,
    // Status word for the SMBus slave
    output logic [swl_pkg::STS_W-1:0]       switch_status_reg_o
);

    // ==========================================================
    // Sequence state
    typedef enum logic [2:0] {
        SWL_IDLE,
        SWL_RD_DRAIN,
        SWL_LOCKED,
        SWL_CPL_DRAIN,
        SWL_UNL_DRAIN
    } swl_state_e;

    swl_state_e                 state;
    swl_state_e                 next_state;
    logic                       dn_locked;
    logic                       next_dn_locked;
    logic                       up_locked;
    logic                       next_up_locked;
    logic [swl_pkg::PW-1:0]     lock_port;
    logic [swl_pkg::PW-1:0]     next_lock_port;
    logic                       cpl_ok;
    logic                       next_cpl_ok;
    logic                       next_up_take;
    logic                       next_dn_take;
    swl_pkg::swl_fwd_s          next_fwd;
    logic [swl_pkg::NPORT-1:0]  drain_vec;
    logic                       drain_wait;
    logic                       drain_done;
    logic [swl_pkg::NPORT-1:0]  map_dn;
    logic                       map_up;
    logic [swl_pkg::STS_W-1:0]  next_status;
    logic                       req_new;
    logic                       cpl_new;

    // ==========================================================
    // Drain watch: which posted queue matters depends on the step
    always_comb begin
        drain_vec  = up_to_dn_empty_i;
        drain_wait = (state == SWL_RD_DRAIN) || (state == SWL_UNL_DRAIN);
        if (state == SWL_CPL_DRAIN) begin
            drain_vec  = dn_to_up_empty_i;
            drain_wait = 1'b1;
        end
    end

    swl_drain u_drain (
        .wait_i  (drain_wait),
        .port_i  (lock_port),
        .empty_i (drain_vec),
        .done_o  (drain_done)
    );

    // ==========================================================
    // Blocking map from the registered lock state
    swl_blk_map u_blk_map (
        .dn_locked_i (dn_locked),
        .up_locked_i (up_locked),
        .port_i      (lock_port),
        .to_dn_o     (map_dn),
        .to_up_o     (map_up)
    );

    // A taken request stays on the inputs for one more edge; ignore it there
    assign req_new = up_req_i.valid && !up_take_o;
    assign cpl_new = dn_cpl_i.valid && !dn_take_o;

    // ==========================================================
    // Sequence next-state logic
    always_comb begin
        next_state     = state;
        next_dn_locked = dn_locked;
        next_up_locked = up_locked;
        next_lock_port = lock_port;
        next_cpl_ok    = cpl_ok;
        next_up_take   = 1'b0;
        next_dn_take   = 1'b0;
        next_fwd       = '0;
        next_fwd.port  = lock_port;
        unique case (state)
            SWL_IDLE: begin
                // Stray completions are not ours while nothing is locked
                next_dn_take = cpl_new;
                if (req_new) begin
                    next_up_take = 1'b1;
                    if (up_req_i.kind == swl_pkg::SWL_REQ_RDLK &&
                        up_req_i.port != swl_pkg::UP_PORT) begin
                        next_lock_port = up_req_i.port;
                        next_state     = SWL_RD_DRAIN;
                    end
                end
            end
            SWL_RD_DRAIN: begin
                if (drain_done) begin
                    next_fwd.rdlk  = 1'b1;
                    next_dn_locked = 1'b1;
                    next_state     = SWL_LOCKED;
                end
            end
            SWL_LOCKED: begin
                // Completions first: the endpoint answers what was sent
                if (cpl_new) begin
                    next_dn_take = 1'b1;
                    if (dn_cpl_i.port == lock_port &&
                        dn_cpl_i.kind != swl_pkg::SWL_CPL_OTHER) begin
                        next_cpl_ok = (dn_cpl_i.kind == swl_pkg::SWL_CPL_DLK);
                        next_state  = SWL_CPL_DRAIN;
                    end
                end else if (req_new) begin
                    next_up_take = 1'b1;
                    unique case (up_req_i.kind)
                        swl_pkg::SWL_REQ_RDLK: begin
                            // Only the locked port is legal here
                            if (up_req_i.port == lock_port) begin
                                next_state = SWL_RD_DRAIN;
                            end
                        end
                        swl_pkg::SWL_REQ_UNLOCK: begin
                            next_state = SWL_UNL_DRAIN;
                        end
                        default: begin
                            // Writes pass through; other kinds are illegal
                            next_state = SWL_LOCKED;
                        end
                    endcase
                end
            end
            SWL_CPL_DRAIN: begin
                if (drain_done) begin
                    next_fwd.cpl    = 1'b1;
                    next_fwd.cpl_ok = cpl_ok;
                    // A failed first attempt also holds upstream until Unlock
                    next_up_locked  = 1'b1;
                    next_state      = SWL_LOCKED;
                end
            end
            SWL_UNL_DRAIN: begin
                if (drain_done) begin
                    next_fwd.unlock = 1'b1;
                    next_dn_locked  = 1'b0;
                    next_up_locked  = 1'b0;
                    next_cpl_ok     = 1'b0;
                    next_state      = SWL_IDLE;
                end
            end
            default: begin
                next_state = SWL_IDLE;
            end
        endcase
    end

    // Sequence registers
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state     <= SWL_IDLE;
            dn_locked <= 1'b0;
            up_locked <= 1'b0;
            lock_port <= swl_pkg::PORT_RST;
            cpl_ok    <= 1'b0;
            up_take_o <= 1'b0;
            dn_take_o <= 1'b0;
            fwd_o     <= '0;
        end else if (ce_i) begin
            state     <= next_state;
            dn_locked <= next_dn_locked;
            up_locked <= next_up_locked;
            lock_port <= next_lock_port;
            cpl_ok    <= next_cpl_ok;
            up_take_o <= next_up_take;
            dn_take_o <= next_dn_take;
            fwd_o     <= next_fwd;
        end
    end

    // ==========================================================
    // Status word; read by the SMBus slave, which never waits on the lock
    always_comb begin
        next_status = '0;
        next_status[swl_pkg::STS_LOCK_BIT] = up_locked;
        next_status[swl_pkg::STS_DNLK_BIT] = dn_locked;
        next_status[swl_pkg::STS_PORT_LSB +: swl_pkg::PW] = lock_port;
    end

    // Blocking outputs; held traffic waits in its own queue, never dropped
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            blk_to_dn_o         <= '0;
            blk_to_up_o         <= 1'b0;
            switch_status_reg_o <= swl_pkg::STS_RST;
        end else if (ce_i) begin
            blk_to_dn_o         <= map_dn;
            blk_to_up_o         <= map_up;
            switch_status_reg_o <= next_status;
        end
    end

    // ==========================================================
    // Checks
    chk_port_stable: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (dn_locked && $past(dn_locked)) |-> $stable(lock_port))
        else $error("locked port changed during lock");

    chk_rd_after_drain: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && state == SWL_RD_DRAIN && !up_to_dn_empty_i[lock_port]) |=> !fwd_o.rdlk)
        else $error("locked read sent before posted drain");

    chk_rd_locks_port: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        fwd_o.rdlk |-> (dn_locked && state == SWL_LOCKED))
        else $error("locked read forwarded without port lock");

    chk_cpl_locks_up: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        fwd_o.cpl |-> up_locked)
        else $error("completion forwarded without upstream lock");

    chk_cpl_drain: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && state == SWL_CPL_DRAIN && !dn_to_up_empty_i[lock_port]) |=> !fwd_o.cpl)
        else $error("completion sent before posted drain");

    chk_blk_up_on: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && up_locked) |=> blk_to_up_o)
        else $error("upstream not blocked in full lock");

    chk_dn_only_free: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && dn_locked && !up_locked) |=> (!blk_to_up_o && $onehot(blk_to_dn_o)))
        else $error("wrong blocking with only downstream lock");

    chk_unlock_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        fwd_o.unlock |-> (!dn_locked && !up_locked && state == SWL_IDLE))
        else $error("unlock forwarded but lock kept");

    chk_unl_drain: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && state == SWL_UNL_DRAIN && !up_to_dn_empty_i[lock_port]) |=> dn_locked)
        else $error("lock released before posted drain");

    chk_cpl_keeps: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (up_locked && !fwd_o.unlock) |=> (up_locked || $past(state) == SWL_UNL_DRAIN))
        else $error("lock lost without unlock");

    chk_status_bit: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && up_locked) |=> switch_status_reg_o[swl_pkg::STS_LOCK_BIT])
        else $error("status bit misses lock");

    chk_blk_held: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && dn_locked && state != SWL_UNL_DRAIN) |=> blk_to_dn_o[lock_port])
        else $error("locked port not held");

    // Invariants of the lock state, the forwarding strobes, the status word and the completion take
    chk_fwd_onehot: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $onehot0({fwd_o.rdlk, fwd_o.cpl, fwd_o.unlock}))
        else $error("two forwarding strobes at once");

    chk_idle_no_lock: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (state == SWL_IDLE) |-> (!dn_locked && !up_locked))
        else $error("lock held while idle");

    chk_up_needs_dn: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        up_locked |-> dn_locked)
        else $error("upstream locked without downstream lock");

    chk_mwr_keeps: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && state == SWL_LOCKED && !cpl_new && req_new &&
         up_req_i.kind == swl_pkg::SWL_REQ_MWR) |=>
        (state == SWL_LOCKED && $stable(up_locked)))
        else $error("memory write changed lock state");

    chk_lk_keeps: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && state == SWL_LOCKED && cpl_new && up_locked &&
         dn_cpl_i.kind == swl_pkg::SWL_CPL_LK) |=> (up_locked && dn_locked))
        else $error("completion without data released the lock");

    chk_fwd_port: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (fwd_o.rdlk || fwd_o.cpl || fwd_o.unlock) |-> (fwd_o.port == lock_port))
        else $error("forwarded to a port other than the locked one");

    chk_free_no_block: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && !dn_locked) |=> (blk_to_dn_o == '0 && !blk_to_up_o))
        else $error("traffic blocked with no lock held");

    chk_status_port: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i |=> (switch_status_reg_o[swl_pkg::STS_PORT_LSB +: swl_pkg::PW] ==
                  $past(lock_port)))
        else $error("status word misses the locked port");

    chk_cpl_take_once: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && dn_take_o) |=> !dn_take_o)
        else $error("completion taken twice");

endmodule

// ### swl_lock_ctrl_tb_top.sv
// Self-checking testbench for the lock sequence controller
`timescale 1ns/10ps
`define chk(name, exp, got) begin total_checks++; if ((got) !== (exp)) begin mismatches++; \
    $display("[FAIL] %s expected %0h seen %0h", name, exp, got); end end
module swl_lock_ctrl_tb_top;
    // ==========================================================
    // Signals
    logic                       clk_i;
    logic                       rst_n_i;
    logic                       ce_i;
    swl_pkg::swl_up_req_s       up_req;
    swl_pkg::swl_dn_cpl_s       dn_cpl;
    swl_pkg::swl_fwd_s          fwd;
    logic [5:0]                 up_e;
    logic [5:0]                 dn_e;
    logic [5:0]                 blk_dn;
    logic                       blk_up;
    logic [7:0]                 sts;
    logic                       up_take;
    logic                       dn_take;
    logic                       fail;
    logic [1:0]                 delay;
    logic [2:0]                 cur;
    logic                       exp_ok;
    int                         mismatches;
    int                         total_checks;
    int                         n_rdlk;
    int                         n_cpl;
    int                         n_unl;

    // ==========================================================
    // Design and far-side endpoint
    swl_lock_ctrl swl_lock_ctrl_i (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
        .up_req_i(up_req), .up_take_o(up_take),
        .dn_cpl_i(dn_cpl), .dn_take_o(dn_take),
        .up_to_dn_empty_i(up_e), .dn_to_up_empty_i(dn_e),
        .fwd_o(fwd), .blk_to_dn_o(blk_dn), .blk_to_up_o(blk_up),
        .switch_status_reg_o(sts)
    );
    swl_ep_model swl_ep_model_i (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .fail_i(fail), .delay_i(delay),
        .fwd_i(fwd), .dn_take_i(dn_take), .dn_cpl_o(dn_cpl)
    );

    // ==========================================================
    // Helpers
    // Expected status word from lock state
    function automatic logic [7:0] exp_sts(input logic up, input logic dn, input logic [2:0] pt);
        logic [7:0] s;
        s = swl_pkg::STS_RST;
        s[swl_pkg::STS_LOCK_BIT] = up;
        s[swl_pkg::STS_DNLK_BIT] = dn;
        s[swl_pkg::STS_PORT_LSB +: 3] = pt;
        return s;
    endfunction

    // Root request held until taken, then released the cycle after
    task automatic send(input swl_pkg::swl_req_e k, input logic [2:0] pt);
        int n;
        up_req.valid = 1'b1;
        up_req.kind  = k;
        up_req.port  = pt;
        n = 0;
        do begin
            @(posedge clk_i);
            #1;
            n++;
        end while (up_take !== 1'b1 && n < 50);
        `chk("up_take", 1'b1, up_take)
        @(posedge clk_i);
        #1;
        up_req.valid = 1'b0;
        up_req.kind  = swl_pkg::SWL_REQ_OTHER;
        up_req.port  = ~pt;
    endtask

    // Counts forwarding strobes over a window; one-cycle pulses sampled each cycle
    task automatic watch(input int cyc);
        n_rdlk = 0;
        n_cpl  = 0;
        n_unl  = 0;
        repeat (cyc) begin
            @(posedge clk_i);
            #1;
            if (fwd.rdlk === 1'b1) n_rdlk++;
            if (fwd.unlock === 1'b1) n_unl++;
            if (fwd.cpl === 1'b1) begin
                n_cpl++;
                `chk("cpl_ok", exp_ok, fwd.cpl_ok)
            end
            if ((fwd.rdlk | fwd.cpl | fwd.unlock) === 1'b1) `chk("fwd_port", cur, fwd.port)
        end
    endtask

    // One complete lock sequence on port p
    task automatic run_seq(input logic [2:0] p, input logic fl);
        logic [5:0] bit_p;
        bit_p = 6'h01 << p;
        cur = p;
        fail = fl;
        exp_ok = !fl;
        delay = 2'($urandom_range(3, 0));
        up_e = 6'($urandom) & ~bit_p;
        dn_e = 6'($urandom) & ~bit_p;
        send(swl_pkg::SWL_REQ_RDLK, p);
        watch(6);
        `chk("rdlk_held", 0, n_rdlk)
        // Enable low freezes the drain even once the queue is empty
        ce_i = 1'b0;
        up_e = up_e | bit_p;
        watch(3);
        `chk("rdlk_frozen", 0, n_rdlk)
        `chk("sts_frozen", exp_sts(1'b0, 1'b0, p), sts)
        ce_i = 1'b1;
        watch(3);
        `chk("rdlk_fwd", 1, n_rdlk)
        `chk("sts_dn", exp_sts(1'b0, 1'b1, p), sts)
        `chk("blk_dn", bit_p, blk_dn)
        `chk("blk_up", 1'b0, blk_up)
        watch(10);
        `chk("cpl_held", 0, n_cpl)
        dn_e = dn_e | bit_p;
        watch(8);
        `chk("cpl_fwd", 1, n_cpl)
        `chk("sts_full", exp_sts(1'b1, 1'b1, p), sts)
        `chk("blk_up_lk", 1'b1, blk_up)
        `chk("blk_dn_lk", bit_p, blk_dn)
        // Writes and further locked reads leave the lock as it is
        send(swl_pkg::SWL_REQ_MWR, p);
        watch(2);
        `chk("sts_mwr", exp_sts(1'b1, 1'b1, p), sts)
        fail = 1'($urandom_range(1, 0));
        exp_ok = !fail;
        up_e = up_e & ~bit_p;
        send(swl_pkg::SWL_REQ_RDLK, p);
        up_e = up_e | bit_p;
        watch(14);
        `chk("rdlk2_fwd", 1, n_rdlk)
        `chk("cpl2_fwd", 1, n_cpl)
        `chk("sts_again", exp_sts(1'b1, 1'b1, p), sts)
        // Unlock waits for upstream posted writes to the locked port
        up_e = up_e & ~bit_p;
        send(swl_pkg::SWL_REQ_UNLOCK, p);
        watch(6);
        `chk("unl_held", 0, n_unl)
        `chk("sts_held", exp_sts(1'b1, 1'b1, p), sts)
        up_e = up_e | bit_p;
        watch(4);
        `chk("unl_fwd", 1, n_unl)
        `chk("sts_free", exp_sts(1'b0, 1'b0, p), sts)
        `chk("blk_free", 7'h00, {blk_dn, blk_up})
    endtask

    // Verdict and end of run
    task automatic results;
        if (mismatches == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // ==========================================================
    // Clock, 250 MHz
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    // Watchdog sized well above the longest expected run
    initial begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        results();
    end

    // Main sequence
    initial begin
        mismatches = 0;
        total_checks = 0;
        rst_n_i = 1'b0;
        ce_i = 1'b1;
        up_req = '{valid: 1'b0, kind: swl_pkg::SWL_REQ_OTHER, port: 3'h0};
        up_e = 6'h3f;
        dn_e = 6'h3f;
        fail = 1'b0;
        delay = 2'h0;
        cur = 3'h0;
        exp_ok = 1'b1;
        void'($urandom(1));
        repeat (6) @(posedge clk_i);
        #1;
        rst_n_i = 1'b1;
        `chk("sts_rst", swl_pkg::STS_RST, sts)
        `chk("blk_rst", 7'h00, {blk_dn, blk_up})
        // Unlock with nothing locked changes nothing
        send(swl_pkg::SWL_REQ_UNLOCK, 3'h3);
        watch(2);
        // A locked read aimed at the upstream port itself locks nothing
        send(swl_pkg::SWL_REQ_RDLK, swl_pkg::UP_PORT);
        watch(4);
        `chk("rdlk_none", 0, n_rdlk)
        `chk("sts_idle", swl_pkg::STS_RST, sts)
        // Boundary ports and both outcomes first, then random sequences
        for (int i = 0; i < 10; i++) begin
            run_seq((i == 0) ? 3'h1 : (i == 1) ? 3'h5 : 3'($urandom_range(5, 1)),
                    (i < 2) ? 1'(i) : 1'($urandom_range(1, 0)));
        end
        results();
    end
endmodule

// ### swl_pkg.sv
// Shared constants and carrier types for the switch bus lock controller
package swl_pkg;

    // ==========================================================
    // Port numbering
    localparam int              NPORT   = 6;
    localparam int              PW      = 3;
    localparam logic [PW-1:0]   UP_PORT = 3'h0;

    // ==========================================================
    // Switch status word layout and reset value
    localparam int              STS_W        = 8;
    localparam int              STS_LOCK_BIT = 0;
    localparam int              STS_DNLK_BIT = 1;
    localparam int              STS_PORT_LSB = 2;
    localparam logic [STS_W-1:0] STS_RST     = 8'h00;
    localparam logic [PW-1:0]   PORT_RST     = 3'h0;

    // ==========================================================
    // Request and completion kinds
    typedef enum logic [1:0] {
        SWL_REQ_MWR,
        SWL_REQ_RDLK,
        SWL_REQ_UNLOCK,
        SWL_REQ_OTHER
    } swl_req_e;

    typedef enum logic [1:0] {
        SWL_CPL_DLK,
        SWL_CPL_LK,
        SWL_CPL_OTHER
    } swl_cpl_e;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic           valid;
        swl_req_e       kind;
        logic [PW-1:0]  port;
    } swl_up_req_s;

    typedef struct packed {
        logic           valid;
        swl_cpl_e       kind;
        logic [PW-1:0]  port;
    } swl_dn_cpl_s;

    typedef struct packed {
        logic           rdlk;
        logic           cpl;
        logic           cpl_ok;
        logic           unlock;
        logic [PW-1:0]  port;
    } swl_fwd_s;

endpackage
